// ---- dee_defines.svh ----
/*
 Constants of the data EEPROM controller: control register fields, key values,
 address map and timing. Assumes inclusion by both ends and the link checker.
*/
`ifndef DEE_DEFINES_SVH
`define DEE_DEFINES_SVH

// ==========================================================
// Register selects on the special function register port
`define DEE_SEL_CTRL 1'h0
`define DEE_SEL_KEY 1'h1

// ==========================================================
// Control register fields
`define DEE_BIT_START 15
`define DEE_BIT_WRITE_ENABLE_BIT 14
`define DEE_BIT_ERR 13
`define DEE_BIT_SKIP 12
`define DEE_BIT_ERASE 6
`define DEE_OP_HI 5
`define DEE_OP_LO 0
`define DEE_CTRL_RESET 16'h0000

// ==========================================================
// Unlock keys
`define DEE_KEY_FIRST 16'h0055
`define DEE_KEY_SECOND 16'h00aa

// ==========================================================
// Operation codes
`define DEE_OPC_ERASE8 6'h1a
`define DEE_OPC_ERASE4 6'h19
`define DEE_OPC_ERASE1 6'h18
`define DEE_OPC_BULK_HI 4'h4
`define DEE_OPC_WRITE_HI 3'h1

// ==========================================================
// Array and address map
`define DEE_WORDS 256
`define DEE_SMALL_WORDS 128
`define DEE_TOP_ADDR 24'h7fffff
`define DEE_PAGE_MSB 15
`define DEE_BASE_PAGE 15'h3fff
`define DEE_ERASED 16'hffff
`define DEE_SPAN1 9'h001
`define DEE_SPAN4 9'h004
`define DEE_SPAN8 9'h008

// ==========================================================
// Timing at a 40 ns clock
`define DEE_CLK_NS 40
`define DEE_OP_TIME_NS 4000000
`define DEE_OP_CYCLES (`DEE_OP_TIME_NS / `DEE_CLK_NS)
`define DEE_TIMER_W 17

`endif

// ---- dee_device.sv ----
/*
 Data EEPROM controller, device end: control and key registers, address and
 data latch from table writes, 256 x 16 array, erase/program sequencer.
 Assumes a CPU end on the same clock that drives dee_if; pin_reset and
 watchdog are asynchronous abort requests from the reset logic.
*/
`timescale 1ns/1ps
`include "dee_defines.svh"
module dee_device
  import dee_pkg::*;
#(
  parameter int OP_CYCLES = `DEE_OP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  dee_if.device bus,
  input wire logic pin_reset,
  input wire logic watchdog,
  output logic busy
);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] word_index(input logic [15:0] lo);
    return lo[8:1];
  endfunction : word_index

  function automatic logic in_array(input logic [7:0] hi, input logic [15:0] lo);
    return {hi, lo[15:9]} == `DEE_BASE_PAGE;
  endfunction : in_array

  function automatic dee_op_t decode(input logic erase, input logic [5:0] opc);
    dee_op_t k;
    k = DEE_OP_NONE;
    if (erase) begin
      if (opc == `DEE_OPC_ERASE8) k = DEE_OP_ERASE8;
      else if (opc == `DEE_OPC_ERASE4) k = DEE_OP_ERASE4;
      else if (opc == `DEE_OPC_ERASE1) k = DEE_OP_ERASE1;
      else if (opc[5:2] == `DEE_OPC_BULK_HI) k = DEE_OP_BULK;
    end else if (opc[5:3] == `DEE_OPC_WRITE_HI) begin
      k = DEE_OP_WRITE;
    end
    return k;
  endfunction : decode

  // ==========================================================
  // Abort request synchronisers
  logic [1:0] abort_meta_ff;
  logic [1:0] abort_sync_ff;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      abort_meta_ff <= 2'h0;
      abort_sync_ff <= 2'h0;
    end else begin
      abort_meta_ff <= {watchdog, pin_reset};
      abort_sync_ff <= abort_meta_ff;
    end
  end

  // ==========================================================
  // Control bits, sequencer state
  logic start_ff;
  logic write_enable_bit_ff;
  logic err_ff;
  logic skip_ff;
  logic erase_sel_ff;
  logic [5:0] opc_ff;
  dee_state_t state_ff;
  dee_op_t kind_ff;
  logic [`DEE_TIMER_W-1:0] timer_ff;
  logic key_half_ff;
  logic key_open_ff;
  logic [7:0] addr_hi_ff;
  logic [15:0] addr_lo_ff;
  logic [15:0] latch_ff;

  logic abort_req;
  logic ctrl_wr;
  logic key_wr;
  logic start_req;
  logic timer_zero;
  logic finish;
  dee_op_t nxt_kind;
  logic [`DEE_TIMER_W-1:0] op_load;

  assign abort_req = |abort_sync_ff;
  assign op_load = `DEE_TIMER_W'(OP_CYCLES - 1);
  assign key_wr = bus.sfr_wr && bus.sfr_sel == `DEE_SEL_KEY;
  // Control register is frozen while a cycle runs
  assign ctrl_wr = bus.sfr_wr && bus.sfr_sel == `DEE_SEL_CTRL && state_ff == DEE_ST_IDLE && !start_ff;
  assign start_req = ctrl_wr && key_open_ff && bus.sfr_wdata[`DEE_BIT_START]
                     && bus.sfr_wdata[`DEE_BIT_WRITE_ENABLE_BIT];
  assign nxt_kind = decode(bus.sfr_wdata[`DEE_BIT_ERASE], bus.sfr_wdata[`DEE_OP_HI:`DEE_OP_LO]);
  assign timer_zero = timer_ff == '0;
  assign finish = (state_ff == DEE_ST_PROG && timer_zero)
                  || (state_ff == DEE_ST_ERASE && timer_zero && kind_ff != DEE_OP_WRITE)
                  || (start_ff && state_ff == DEE_ST_IDLE && kind_ff == DEE_OP_NONE);

  // ==========================================================
  // Unlock sequence: 55h then AAh opens a one-cycle window
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      key_half_ff <= 1'b0;
      key_open_ff <= 1'b0;
    end else begin
      key_open_ff <= key_wr && key_half_ff && bus.sfr_wdata == `DEE_KEY_SECOND;
      if (key_wr) begin
        key_half_ff <= bus.sfr_wdata == `DEE_KEY_FIRST;
      end else if (bus.sfr_wr) begin
        key_half_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_ff <= 1'b0;
      write_enable_bit_ff <= 1'b0;
      skip_ff <= 1'b0;
      erase_sel_ff <= 1'b0;
      opc_ff <= 6'h00;
      kind_ff <= DEE_OP_NONE;
    end else if (ctrl_wr) begin
      write_enable_bit_ff <= bus.sfr_wdata[`DEE_BIT_WRITE_ENABLE_BIT];
      skip_ff <= bus.sfr_wdata[`DEE_BIT_SKIP];
      erase_sel_ff <= bus.sfr_wdata[`DEE_BIT_ERASE];
      opc_ff <= bus.sfr_wdata[`DEE_OP_HI:`DEE_OP_LO];
      if (start_req) begin
        start_ff <= 1'b1;
        kind_ff <= nxt_kind;
      end
    end else if (finish || (abort_req && start_ff)) begin
      start_ff <= 1'b0;
      write_enable_bit_ff <= 1'b0;
    end
  end

  // Abort wins over any clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      err_ff <= 1'b0;
    end else if (abort_req && start_ff) begin
      err_ff <= 1'b1;
    end else if (finish) begin
      err_ff <= 1'b0;
    end else if (ctrl_wr) begin
      err_ff <= bus.sfr_wdata[`DEE_BIT_ERR];
    end
  end

  // ==========================================================
  // Sequencer; runs beside the CPU, which is never stalled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= DEE_ST_IDLE;
      timer_ff <= '0;
    end else if (abort_req && start_ff) begin
      state_ff <= DEE_ST_IDLE;
      timer_ff <= '0;
    end else begin
      unique case (state_ff)
        DEE_ST_IDLE: begin
          if (start_ff && kind_ff != DEE_OP_NONE) begin
            timer_ff <= op_load;
            if (kind_ff == DEE_OP_WRITE && skip_ff) state_ff <= DEE_ST_PROG;
            else state_ff <= DEE_ST_ERASE;
          end
        end
        DEE_ST_ERASE: begin
          if (!timer_zero) begin
            timer_ff <= timer_ff - 1'b1;
          end else if (kind_ff == DEE_OP_WRITE) begin
            state_ff <= DEE_ST_PROG;
            timer_ff <= op_load;
          end else begin
            state_ff <= DEE_ST_IDLE;
          end
        end
        DEE_ST_PROG: begin
          if (!timer_zero) timer_ff <= timer_ff - 1'b1;
          else state_ff <= DEE_ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Address and data capture from low-word table writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_hi_ff <= 8'h00;
      addr_lo_ff <= 16'h0000;
      latch_ff <= 16'h0000;
    end else if (bus.tbl_wr && !start_ff) begin
      addr_hi_ff <= {1'b0, bus.tbl_addr[22:16]};
      addr_lo_ff <= {bus.tbl_addr[15:1], 1'b0};
      latch_ff <= bus.tbl_wdata;
    end
  end

  // ==========================================================
  // Array; not reset, contents are nonvolatile
  logic [15:0] mem [`DEE_WORDS];
  logic [8:0] span;
  logic [7:0] base_idx;
  logic op_hit;
  always_comb begin
    span = `DEE_SPAN1;
    unique case (kind_ff)
      DEE_OP_ERASE4: span = `DEE_SPAN4;
      DEE_OP_ERASE8: span = `DEE_SPAN8;
      default: span = `DEE_SPAN1;
    endcase
  end
  assign base_idx = word_index(addr_lo_ff);
  assign op_hit = in_array(addr_hi_ff, addr_lo_ff) || kind_ff == DEE_OP_BULK;

  always_ff @(posedge clk_sys) begin
    if (timer_zero && op_hit && !(abort_req && start_ff)) begin
      if (state_ff == DEE_ST_ERASE) begin
        for (int i = 0; i < `DEE_WORDS; i++) begin
          if (kind_ff == DEE_OP_BULK || {1'b0, 8'(i - int'(base_idx))} < span) begin
            mem[i] <= `DEE_ERASED;
          end
        end
      end else if (state_ff == DEE_ST_PROG) begin
        mem[base_idx] <= latch_ff;
      end
    end
  end

  // ==========================================================
  // Outputs
  logic [15:0] rdata_ff;
  logic rvalid_ff;
  logic [15:0] ctrl_rd_ff;
  logic done_ff;
  logic busy_ff;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
      ctrl_rd_ff <= `DEE_CTRL_RESET;
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      rvalid_ff <= bus.tbl_rd;
      if (bus.tbl_rd) begin
        rdata_ff <= mem[word_index(bus.tbl_addr[15:0])];
      end
      ctrl_rd_ff <= {start_ff, write_enable_bit_ff, err_ff, skip_ff, 5'h00, erase_sel_ff, opc_ff};
      done_ff <= finish && !(abort_req && start_ff);
      busy_ff <= state_ff != DEE_ST_IDLE;
    end
  end

  assign bus.tbl_rdata = rdata_ff;
  assign bus.tbl_rvalid = rvalid_ff;
  assign bus.ctrl_value = ctrl_rd_ff;
  assign bus.op_done = done_ff;
  assign busy = busy_ff;

endmodule : dee_device

// ---- dee_host.sv ----
/*
 CPU end of the data EEPROM link: turns one erase or write command into the
 configure, table access, unlock and start sequence, then waits.
 Assumes a device end on the same clock behind dee_if.
*/
`timescale 1ns/1ps
`include "dee_defines.svh"
module dee_host
  import dee_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  dee_if.host bus,
  input wire logic cmd_valid,
  input wire dee_op_t cmd_kind,
  input wire logic [23:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic cmd_skip_erase,
  output logic cmd_ready,
  output logic [15:0] rsp_data,
  output logic rsp_valid,
  output logic rsp_error,
  output logic completion_irq_flag
);

  function automatic logic [15:0] ctrl_word(input dee_op_t k, input logic skip, input logic go);
    logic [15:0] w;
    w = 16'h0000;
    w[`DEE_BIT_START] = go;
    w[`DEE_BIT_WRITE_ENABLE_BIT] = 1'b1;
    w[`DEE_BIT_SKIP] = skip;
    w[`DEE_BIT_ERASE] = k != DEE_OP_WRITE;
    unique case (k)
      DEE_OP_ERASE1: w[`DEE_OP_HI:`DEE_OP_LO] = `DEE_OPC_ERASE1;
      DEE_OP_ERASE4: w[`DEE_OP_HI:`DEE_OP_LO] = `DEE_OPC_ERASE4;
      DEE_OP_ERASE8: w[`DEE_OP_HI:`DEE_OP_LO] = `DEE_OPC_ERASE8;
      DEE_OP_BULK: w[`DEE_OP_HI:`DEE_OP_LO] = {`DEE_OPC_BULK_HI, 2'h0};
      default: w[`DEE_OP_HI:`DEE_OP_LO] = {`DEE_OPC_WRITE_HI, 3'h0};
    endcase
    return w;
  endfunction : ctrl_word

  dee_hstate_t st_ff;
  dee_op_t kind_ff;
  logic skip_ff;
  logic [23:0] addr_ff;
  logic [15:0] data_ff;
  logic sfr_wr_ff;
  logic sfr_sel_ff;
  logic [15:0] sfr_wdata_ff;
  logic tbl_wr_ff;
  logic tbl_rd_ff;
  logic ready_ff;
  logic [15:0] rsp_data_ff;
  logic rsp_valid_ff;
  logic rsp_error_ff;
  logic irq_ff;

  // ==========================================================
  // Sequence, issued back to back so no interrupt can split it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= DEE_H_IDLE;
      kind_ff <= DEE_OP_NONE;
      skip_ff <= 1'b0;
      addr_ff <= 24'h000000;
      data_ff <= 16'h0000;
      sfr_wr_ff <= 1'b0;
      sfr_sel_ff <= `DEE_SEL_CTRL;
      sfr_wdata_ff <= 16'h0000;
      tbl_wr_ff <= 1'b0;
      tbl_rd_ff <= 1'b0;
      ready_ff <= 1'b0;
      rsp_data_ff <= 16'h0000;
      rsp_valid_ff <= 1'b0;
      rsp_error_ff <= 1'b0;
    end else begin
      sfr_wr_ff <= 1'b0;
      tbl_wr_ff <= 1'b0;
      tbl_rd_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      unique case (st_ff)
        DEE_H_IDLE: begin
          ready_ff <= 1'b1;
          if (ready_ff && cmd_valid) begin
            ready_ff <= 1'b0;
            kind_ff <= cmd_kind;
            skip_ff <= cmd_skip_erase;
            addr_ff <= cmd_addr;
            data_ff <= cmd_data;
            if (cmd_kind == DEE_OP_READ) begin
              st_ff <= DEE_H_RD;
              tbl_rd_ff <= 1'b1;
            end else begin
              st_ff <= DEE_H_CFG;
              sfr_wr_ff <= 1'b1;
              sfr_sel_ff <= `DEE_SEL_CTRL;
              sfr_wdata_ff <= ctrl_word(cmd_kind, cmd_skip_erase, 1'b0);
            end
          end
        end
        DEE_H_CFG: begin
          st_ff <= DEE_H_TBL;
          tbl_wr_ff <= 1'b1;
        end
        DEE_H_TBL: begin
          st_ff <= DEE_H_KEY1;
          sfr_wr_ff <= 1'b1;
          sfr_sel_ff <= `DEE_SEL_KEY;
          sfr_wdata_ff <= `DEE_KEY_FIRST;
        end
        DEE_H_KEY1: begin
          st_ff <= DEE_H_KEY2;
          sfr_wr_ff <= 1'b1;
          sfr_wdata_ff <= `DEE_KEY_SECOND;
        end
        DEE_H_KEY2: begin
          st_ff <= DEE_H_START;
          sfr_wr_ff <= 1'b1;
          sfr_sel_ff <= `DEE_SEL_CTRL;
          sfr_wdata_ff <= ctrl_word(kind_ff, skip_ff, 1'b1);
        end
        DEE_H_START: st_ff <= DEE_H_SETTLE;
        DEE_H_SETTLE: st_ff <= DEE_H_WAIT;
        DEE_H_WAIT: begin
          if (!bus.ctrl_value[`DEE_BIT_START]) begin
            st_ff <= DEE_H_IDLE;
            rsp_valid_ff <= 1'b1;
            rsp_error_ff <= bus.ctrl_value[`DEE_BIT_ERR];
          end
        end
        DEE_H_RD: st_ff <= DEE_H_RDWAIT;
        DEE_H_RDWAIT: begin
          if (bus.tbl_rvalid) begin
            st_ff <= DEE_H_IDLE;
            rsp_valid_ff <= 1'b1;
            rsp_error_ff <= 1'b0;
            rsp_data_ff <= bus.tbl_rdata;
          end
        end
        default: st_ff <= DEE_H_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Completion flag; a completion in the clearing cycle wins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else if (bus.op_done) begin
      irq_ff <= 1'b1;
    end else if (st_ff == DEE_H_CFG) begin
      irq_ff <= 1'b0;
    end
  end

  assign bus.sfr_wr = sfr_wr_ff;
  assign bus.sfr_sel = sfr_sel_ff;
  assign bus.sfr_wdata = sfr_wdata_ff;
  assign bus.tbl_wr = tbl_wr_ff;
  assign bus.tbl_rd = tbl_rd_ff;
  assign bus.tbl_addr = addr_ff;
  assign bus.tbl_wdata = data_ff;
  assign cmd_ready = ready_ff;
  assign rsp_data = rsp_data_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_error = rsp_error_ff;
  assign completion_irq_flag = irq_ff;

endmodule : dee_host

// ---- dee_if.sv ----
/*
 Link between the CPU side and the data EEPROM controller: register writes,
 table reads and writes, control readback and completion event.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface dee_if;
  logic sfr_wr;
  logic sfr_sel;
  logic [15:0] sfr_wdata;
  logic tbl_wr;
  logic tbl_rd;
  logic [23:0] tbl_addr;
  logic [15:0] tbl_wdata;
  logic [15:0] tbl_rdata;
  logic tbl_rvalid;
  logic [15:0] ctrl_value;
  logic op_done;

  modport device (
    input sfr_wr, sfr_sel, sfr_wdata, tbl_wr, tbl_rd, tbl_addr, tbl_wdata,
    output tbl_rdata, tbl_rvalid, ctrl_value, op_done
  );
  modport host (
    output sfr_wr, sfr_sel, sfr_wdata, tbl_wr, tbl_rd, tbl_addr, tbl_wdata,
    input tbl_rdata, tbl_rvalid, ctrl_value, op_done
  );
endinterface : dee_if

// ---- dee_link_assertions.sv ----
/*
 Checker of the data EEPROM link: read answers, start gating, completion.
 Assumes the testbench instantiates it beside the dee_if joining both ends.
*/
`timescale 1ns/1ps
`include "dee_defines.svh"
module dee_link_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sfr_wr,
  input wire logic sfr_sel,
  input wire logic [15:0] sfr_wdata,
  input wire logic tbl_rd,
  input wire logic [15:0] tbl_rdata,
  input wire logic tbl_rvalid,
  input wire logic [15:0] ctrl_value,
  input wire logic op_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire key1_w = sfr_wr && sfr_sel == `DEE_SEL_KEY && sfr_wdata == `DEE_KEY_FIRST;
  wire key2_w = sfr_wr && sfr_sel == `DEE_SEL_KEY && sfr_wdata == `DEE_KEY_SECOND;
  wire go_w = sfr_wr && sfr_sel == `DEE_SEL_CTRL && sfr_wdata[`DEE_BIT_START];
  wire start_w = ctrl_value[`DEE_BIT_START];

  // ==========================================================
  // Table reads
  a_read_answered: assert property (tbl_rd |=> tbl_rvalid)
    else $error("read not answered");
  a_answer_cause: assert property (tbl_rvalid |-> $past(tbl_rd))
    else $error("answer without read");
  a_rdata_held: assert property (!tbl_rvalid |-> $stable(tbl_rdata))
    else $error("read data moved");

  // ==========================================================
  // Start gating and completion
  a_start_keyed: assert property ($rose(start_w) |-> $past(go_w, 2) && $past(key2_w, 3) && $past(key1_w, 4))
    else $error("start without key pair");
  a_start_write_enable_bit: assert property ($rose(start_w) |-> ctrl_value[`DEE_BIT_WRITE_ENABLE_BIT])
    else $error("start without write enable");
  a_done_clears: assert property (op_done |-> ##[0:2] (!start_w && !ctrl_value[`DEE_BIT_WRITE_ENABLE_BIT]))
    else $error("start or enable left set");
  a_done_pulse: assert property (op_done |=> !op_done)
    else $error("completion not a pulse");
  a_start_fall: assert property ($fell(start_w) |-> ctrl_value[`DEE_BIT_ERR] || $past(op_done) || $past(op_done, 2))
    else $error("start cleared without cause");
  a_done_no_error: assert property (op_done |-> ##[0:2] !ctrl_value[`DEE_BIT_ERR])
    else $error("error flag after success");
endmodule : dee_link_assertions

// ---- dee_pkg.sv ----
/*
 Types shared by both ends of the data EEPROM controller.
 Assumes dee_defines.svh is on the include path.
*/
package dee_pkg;
  typedef enum logic [2:0] {
    DEE_OP_NONE = 3'b000,
    DEE_OP_ERASE1 = 3'b001,
    DEE_OP_ERASE4 = 3'b010,
    DEE_OP_ERASE8 = 3'b011,
    DEE_OP_BULK = 3'b100,
    DEE_OP_WRITE = 3'b101,
    DEE_OP_READ = 3'b110
  } dee_op_t;

  typedef enum logic [1:0] {
    DEE_ST_IDLE = 2'b00,
    DEE_ST_ERASE = 2'b01,
    DEE_ST_PROG = 2'b10
  } dee_state_t;

  typedef enum logic [3:0] {
    DEE_H_IDLE = 4'b0000,
    DEE_H_CFG = 4'b0001,
    DEE_H_TBL = 4'b0010,
    DEE_H_KEY1 = 4'b0011,
    DEE_H_KEY2 = 4'b0100,
    DEE_H_START = 4'b0101,
    DEE_H_SETTLE = 4'b0110,
    DEE_H_WAIT = 4'b0111,
    DEE_H_RD = 4'b1000,
    DEE_H_RDWAIT = 4'b1001
  } dee_hstate_t;
endpackage : dee_pkg

// ---- dee_tb.sv ----
/*
 Testbench: host and device joined by dee_if, plus a second device driven
 directly to try bad unlock sequences. Assumes OP_CYCLES of 8.
*/
`timescale 1ns/1ps
module dee_tb
  import dee_pkg::*;
;
  localparam int OPC = 8;
  localparam logic [17:0] NO = 18'h0;
  localparam logic [17:0] K1 = {2'b11, 16'h0055};
  localparam logic [17:0] K2 = {2'b11, 16'h00aa};
  localparam logic [17:0] GO = {2'b10, 16'hc058};
  logic clk_sys, rst, cmd_valid, cmd_skip_erase, pin_reset, watchdog;
  dee_op_t cmd_kind;
  logic [23:0] cmd_addr;
  logic [15:0] cmd_data, rsp_data, got;
  logic cmd_ready, rsp_valid, rsp_error, completion_irq_flag, busy, busy2, err;
  int failures, n_compared, cyc;
  dee_if bus ();
  dee_if bus2 ();
  dee_device #(.OP_CYCLES(OPC)) i_dee_device (.clk_sys(clk_sys), .rst(rst), .bus(bus), .pin_reset(pin_reset),
    .watchdog(watchdog), .busy(busy));
  dee_device #(.OP_CYCLES(OPC)) i_dee_device_raw (.clk_sys(clk_sys), .rst(rst), .bus(bus2), .pin_reset(1'b0),
    .watchdog(1'b0), .busy(busy2));
  dee_host i_dee_host (.clk_sys(clk_sys), .rst(rst), .bus(bus), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_skip_erase(cmd_skip_erase), .cmd_ready(cmd_ready),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_error(rsp_error), .completion_irq_flag(completion_irq_flag));
  dee_link_assertions i_dee_link_assertions (.clk_sys(clk_sys), .rst(rst), .sfr_wr(bus.sfr_wr),
    .sfr_sel(bus.sfr_sel), .sfr_wdata(bus.sfr_wdata), .tbl_rd(bus.tbl_rd), .tbl_rdata(bus.tbl_rdata),
    .tbl_rvalid(bus.tbl_rvalid), .ctrl_value(bus.ctrl_value), .op_done(bus.op_done));

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  // One host command; ab > 0 raises an abort source ab cycles after acceptance
  task automatic cmd(input dee_op_t k, input logic [23:0] a, input logic [15:0] d, input logic s, input int ab,
    input logic wd);
    for (int i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(posedge clk_sys);
    if (cmd_ready !== 1'b1) begin
      $display("Error cmd_ready expected 1 seen %b", cmd_ready);
      failures++;
      conclude();
    end
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_skip_erase <= s;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cyc = 0;
    do begin
      @(posedge clk_sys);
      cyc++;
      if (ab > 0 && cyc == ab) begin
        pin_reset <= !wd;
        watchdog <= wd;
      end
      if (cyc == ab + 4) begin
        pin_reset <= 1'b0;
        watchdog <= 1'b0;
      end
    end while (rsp_valid !== 1'b1 && cyc < 200);
    if (cyc >= 200) begin
      $display("Error response expected 1 seen 0");
      failures++;
      conclude();
    end
    got = rsp_data;
    err = rsp_error;
  endtask : cmd

  // ==========================================================
  // Scenarios
  task automatic t_rw();
    int t0;
    cmd(DEE_OP_WRITE, 24'hfffe21, 16'h1234, 1'b0, 0, 1'b0);
    t0 = cyc;
    check("irq flag", 16'h1, {15'h0, completion_irq_flag});
    check("start write_enable_bit", 16'h0, {14'h0, bus.ctrl_value[15:14]});
    check("busy idle", 16'h0, {15'h0, busy});
    cmd(DEE_OP_READ, 24'h7ffe20, 16'h0, 1'b0, 0, 1'b0);
    check("read back", 16'h1234, got);
    cmd(DEE_OP_ERASE1, 24'h7ffe20, 16'h0, 1'b0, 0, 1'b0);
    cmd(DEE_OP_WRITE, 24'h7ffe20, 16'h5a5a, 1'b1, 0, 1'b0);
    check("skip faster", 16'h1, {15'h0, t0 >= cyc + OPC});
    cmd(DEE_OP_READ, 24'h7ffe20, 16'h0, 1'b0, 0, 1'b0);
    check("program only", 16'h5a5a, got);
  endtask : t_rw

  task automatic t_erase();
    dee_op_t k[3] = '{DEE_OP_ERASE1, DEE_OP_ERASE4, DEE_OP_ERASE8};
    int n[3] = '{1, 4, 8};
    logic [23:0] b;
    for (int i = 0; i < 3; i++) begin
      b = 24'h7ffe40 + 24'(i * 32);
      cmd(DEE_OP_WRITE, b + 24'(2 * n[i] - 2), 16'h0f00, 1'b0, 0, 1'b0);
      cmd(DEE_OP_WRITE, b + 24'(2 * n[i]), 16'h00f0, 1'b0, 0, 1'b0);
      cmd(k[i], b, 16'h0, 1'b0, 0, 1'b0);
      cmd(DEE_OP_READ, b + 24'(2 * n[i] - 2), 16'h0, 1'b0, 0, 1'b0);
      check("erased last", 16'hffff, got);
      cmd(DEE_OP_READ, b + 24'(2 * n[i]), 16'h0, 1'b0, 0, 1'b0);
      check("kept next", 16'h00f0, got);
    end
  endtask : t_erase

  task automatic t_bulk();
    cmd(DEE_OP_BULK, 24'h000000, 16'h0, 1'b0, 0, 1'b0);
    cmd(DEE_OP_READ, 24'h7ffe20, 16'h0, 1'b0, 0, 1'b0);
    check("bulk low", 16'hffff, got);
    cmd(DEE_OP_READ, 24'h7ffe42, 16'h0, 1'b0, 0, 1'b0);
    check("bulk other", 16'hffff, got);
  endtask : t_bulk

  task automatic t_abort();
    cmd(DEE_OP_WRITE, 24'h7ffe30, 16'hbeef, 1'b0, 0, 1'b0);
    for (int i = 0; i < 2; i++) begin
      cmd(DEE_OP_WRITE, 24'h7ffe30, 16'h1111, 1'b0, 10, i[0]);
      check("abort error", 16'h1, {15'h0, err});
      check("abort irq", 16'h0, {15'h0, completion_irq_flag});
      cmd(DEE_OP_READ, 24'h7ffe30, 16'h0, 1'b0, 0, 1'b0);
      check("abort kept", 16'hbeef, got);
    end
    cmd(DEE_OP_WRITE, 24'h7ffe30, 16'h2222, 1'b0, 0, 1'b0);
    check("error cleared", 16'h0, {15'h0, err});
  endtask : t_abort

  // Drives the second device directly: entries are {write, select, data}
  task automatic raw(input logic [17:0] w0, w1, w2, w3, input logic exp);
    logic [17:0] w[4] = '{w0, w1, w2, w3};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      bus2.sfr_wr <= w[i][17];
      bus2.sfr_sel <= w[i][16];
      bus2.sfr_wdata <= w[i][15:0];
    end
    @(posedge clk_sys);
    bus2.sfr_wr <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check("raw start", {15'h0, exp}, {15'h0, bus2.ctrl_value[15]});
    check("raw busy", {15'h0, exp}, {15'h0, busy2});
  endtask : raw

  task automatic t_keys();
    raw(NO, NO, NO, GO, 1'b0);
    raw(NO, K2, K1, GO, 1'b0);
    raw(K1, K2, NO, GO, 1'b0);
    raw(NO, K1, K2, GO, 1'b1);
  endtask : t_keys

  // ==========================================================
  // Main sequence
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    rst = 1'b1;
    {cmd_valid, cmd_skip_erase, pin_reset, watchdog} = 4'h0;
    cmd_kind = DEE_OP_NONE;
    cmd_addr = 24'h0;
    cmd_data = 16'h0;
    {bus2.sfr_wr, bus2.sfr_sel, bus2.tbl_wr, bus2.tbl_rd} = 4'h0;
    bus2.sfr_wdata = 16'h0;
    bus2.tbl_addr = 24'h0;
    bus2.tbl_wdata = 16'h0;
    failures = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_rw();
    t_erase();
    t_bulk();
    t_abort();
    t_keys();
    conclude();
  end
endmodule : dee_tb
